// >>> src/sp_pkg.sv
// Shared constants and types of the serial port control block
package sp_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADR_RX_CTL = 8'h18;
    localparam logic [7:0] ADR_TX_DATA = 8'h19;
    localparam logic [7:0] ADR_RX_BUF = 8'h1a;
    localparam logic [7:0] ADR_STATUS = 8'h1b;
    localparam logic [7:0] ADR_TX_CTL = 8'h98;
    localparam logic [7:0] ADR_DIV_LO = 8'h99;
    localparam logic [7:0] ADR_DIV_HI = 8'h9a;
    localparam logic [7:0] ADR_BAUD = 8'h9b;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int B_CLK_MASTER = 7;
    localparam int B_NINE_SEND = 6;
    localparam int B_TX_EN = 5;
    localparam int B_SYNC = 4;
    localparam int B_BREAK = 3;
    localparam int B_HIGH_RATE = 2;
    localparam int B_SH_EMPTY = 1;
    localparam int B_NINTH_SEND = 0;
    localparam int B_PORT_EN = 7;
    localparam int B_NINE_RCV = 6;
    localparam int B_SRE = 5;
    localparam int B_CRE = 4;
    localparam int B_ADDR_DET = 3;
    localparam int B_AB_OVF = 7;
    localparam int B_RX_IDLE = 6;
    localparam int B_POL_INV = 4;
    localparam int B_WIDE = 3;
    localparam int B_WAKE = 1;
    localparam int B_AB_EN = 0;
    localparam int P_NINTH = 9;
    // ---------------------------------------------------------------
    // Masks and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] M_BREAK = 8'h08;
    localparam logic [7:0] M_SH_EMPTY = 8'h02;
    localparam logic [7:0] M_SRE = 8'h20;
    localparam logic [7:0] M_WAKE = 8'h02;
    localparam logic [7:0] M_AB_EN = 8'h01;
    localparam logic [7:0] RXC_WR_MASK = 8'hf8;
    localparam logic [7:0] BAUD_WR_MASK = 8'h1b;
    localparam logic [7:0] BAUD_RSVD = 8'h24;
    localparam logic [7:0] REG_RST = 8'h00;
    // ---------------------------------------------------------------
    // Timing and frame lengths
    // ---------------------------------------------------------------
    localparam logic [6:0] TICKS_SLOW = 7'h40;
    localparam logic [6:0] TICKS_MID = 7'h10;
    localparam logic [6:0] TICKS_FAST = 7'h04;
    localparam logic [6:0] TICKS_SYNC = 7'h04;
    localparam logic [3:0] LEN_D8 = 4'h8;
    localparam logic [3:0] LEN_D9 = 4'h9;
    localparam logic [3:0] LEN_A8 = 4'ha;
    localparam logic [3:0] LEN_A9 = 4'hb;
    localparam logic [3:0] LEN_BREAK = 4'he;
    localparam logic [3:0] LEN_ONE = 4'h1;
    localparam logic [2:0] AB_RISES = 3'h4;

    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_RUN = 1'b1} sp_tx_e;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
    } sp_rx_e;
    typedef enum logic [1:0] {
        AB_IDLE = 2'b00, AB_FALL = 2'b01, AB_RISE = 2'b10, AB_MEAS = 2'b11
    } sp_ab_e;

    typedef struct packed {
        logic tck_o;
        logic tck_oe_n;
        logic rdt_o;
        logic rdt_oe_n;
    } sp_pins_s;
endpackage : sp_pkg

// >>> src/sp_serial_port.sv
// Serial port control: registers, baud generator, transmitter, receiver
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module sp_serial_port (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Line pins
    input wire logic transmit_clock_pin_in,
    input wire logic receive_data_pin_in,
    output sp_pkg::sp_pins_s pins_out,
    // Events
    output logic receive_flag_out,
    output logic wake_out
);
    import sp_pkg::*;

    function automatic logic maj3(input logic [2:0] h);
        maj3 = (h[0] & h[1]) | (h[0] & h[2]) | (h[1] & h[2]);
    endfunction : maj3

    function automatic logic [6:0] bit_ticks(input logic s, h, w);
        if (s) bit_ticks = TICKS_SYNC;
        else if (h & w) bit_ticks = TICKS_FAST;
        else if (h | w) bit_ticks = TICKS_MID;
        else bit_ticks = TICKS_SLOW;
    endfunction : bit_ticks

    function automatic logic [13:0] tx_frame(input logic s, b, n, n9,
                                             input logic [7:0] d);
        if (s) tx_frame = n ? {5'h00, n9, d} : {6'h00, d};
        else if (b) tx_frame = {1'b1, 13'h0000};
        else if (n) tx_frame = {4'hf, n9, d, 1'b0};
        else tx_frame = {4'hf, 1'b1, d, 1'b0};
    endfunction : tx_frame

    function automatic logic [3:0] tx_len(input logic s, b, n);
        if (s) tx_len = n ? LEN_D9 : LEN_D8;
        else if (b) tx_len = LEN_BREAK;
        else tx_len = n ? LEN_A9 : LEN_A8;
    endfunction : tx_len

    // ---------------------------------------------------------------
    // Registers and decode
    // ---------------------------------------------------------------
    logic [7:0] txc_q, rxc_q, bdc_q, dlo_q, dhi_q, txd_q, buf_q, rdata_q;
    logic [7:0] txc_d, rxc_d, bdc_d, dlo_d, dhi_d;
    logic txf_q, buff_q, framing_error_q, ovr_q, n9r_q, abovf_q, wfl_q, warm_q;
    logic rx_s1_q, rx_s2_q, rx_s3_q, ck_s1_q, ck_s2_q, ck_s3_q;
    logic [7:0] rd_val;
    sp_pins_s pins_q, pins_d;

    wire logic wr_txc = reg_wr_in & (reg_addr_in == ADR_TX_CTL);
    wire logic wr_rxc = reg_wr_in & (reg_addr_in == ADR_RX_CTL);
    wire logic wr_bdc = reg_wr_in & (reg_addr_in == ADR_BAUD);
    wire logic wr_dlo = reg_wr_in & (reg_addr_in == ADR_DIV_LO);
    wire logic wr_dhi = reg_wr_in & (reg_addr_in == ADR_DIV_HI);
    wire logic wr_txd = reg_wr_in & (reg_addr_in == ADR_TX_DATA);
    wire logic rd_buf = reg_rd_in & (reg_addr_in == ADR_RX_BUF);

    wire logic pen = rxc_q[B_PORT_EN];
    wire logic syn = txc_q[B_SYNC];
    wire logic mst = txc_q[B_CLK_MASTER];
    wire logic pol = bdc_q[B_POL_INV];
    wire logic wide = bdc_q[B_WIDE];
    wire logic cre = rxc_q[B_CRE];
    wire logic nine_r = rxc_q[B_NINE_RCV];
    wire logic sre = rxc_q[B_SRE] & syn & mst;
    wire logic rx_req = syn & (cre | sre);

    // ---------------------------------------------------------------
    // Baud generator
    // ---------------------------------------------------------------
    logic [15:0] bg_q;
    wire logic [15:0] div = wide ? {dhi_q, dlo_q} : {8'h00, dlo_q};
    wire logic tick = pen & (bg_q == 16'h0000);
    wire logic [6:0] bt = bit_ticks(syn, txc_q[B_HIGH_RATE], wide);
    wire logic [6:0] half = bt >> 1;
    wire logic [6:0] last = bt - 7'h01;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) bg_q <= 16'h0000;
        else if (!pen || wr_dlo || wr_dhi) bg_q <= 16'h0000;
        else if (tick) bg_q <= div;
        else bg_q <= bg_q - 16'h0001;
    end

    // ---------------------------------------------------------------
    // Pin synchronisers and sampling
    // ---------------------------------------------------------------
    logic [2:0] hist_q;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {rx_s1_q, rx_s2_q, rx_s3_q} <= 3'h7;
            {ck_s1_q, ck_s2_q, ck_s3_q} <= 3'h7;
            hist_q <= 3'h7;
        end else begin
            {rx_s3_q, rx_s2_q, rx_s1_q} <= {rx_s2_q, rx_s1_q, receive_data_pin_in};
            {ck_s3_q, ck_s2_q, ck_s1_q} <= {ck_s2_q, ck_s1_q, transmit_clock_pin_in};
            if (tick) hist_q <= {hist_q[1:0], rx_s2_q};
        end
    end

    wire logic maj = maj3(hist_q);
    wire logic rx_fall = rx_s3_q & ~rx_s2_q;
    wire logic rx_rise = ~rx_s3_q & rx_s2_q;
    wire logic ck_up = ~ck_s3_q & ck_s2_q;
    wire logic ck_dn = ck_s3_q & ~ck_s2_q;
    wire logic ck_act = pol ? ck_up : ck_dn;
    wire logic ck_inact = pol ? ck_dn : ck_up;

    // ---------------------------------------------------------------
    // Transmitter
    // ---------------------------------------------------------------
    sp_tx_e tx_st_q;
    logic [13:0] tsh_q;
    logic [3:0] tleft_q;
    logic [6:0] tcnt_q;
    logic tbrk_q;
    wire logic tx_go = pen & txc_q[B_TX_EN] & ~rx_req;
    wire logic tx_idle = (tx_st_q == TX_IDLE);
    wire logic tx_load = tx_go & txf_q & tx_idle;
    wire logic brk_now = ~syn & txc_q[B_BREAK];
    wire logic tx_slv = syn & ~mst;
    wire logic tx_end = tx_slv ? ck_inact : (tick & (tcnt_q == last));
    wire logic tx_done = ~tx_idle & tx_end & (tleft_q == LEN_ONE);
    wire logic tx_line = tx_idle ? 1'b1 : tsh_q[0];

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_st_q <= TX_IDLE;
            tsh_q <= 14'h3fff;
            tleft_q <= 4'h0;
            tcnt_q <= 7'h00;
            tbrk_q <= 1'b0;
        end else if (!tx_go) begin
            tx_st_q <= TX_IDLE;
            tcnt_q <= 7'h00;
        end else if (tx_load) begin
            tx_st_q <= TX_RUN;
            tsh_q <= tx_frame(syn, brk_now, txc_q[B_NINE_SEND],
                              txc_q[B_NINTH_SEND], txd_q);
            tleft_q <= tx_len(syn, brk_now, txc_q[B_NINE_SEND]);
            tcnt_q <= 7'h00;
            tbrk_q <= brk_now;
        end else if (!tx_idle) begin
            if (tick & ~tx_slv)
                tcnt_q <= (tcnt_q == last) ? 7'h00 : tcnt_q + 7'h01;
            if (tx_end) begin
                tsh_q <= {1'b1, tsh_q[13:1]};
                tleft_q <= tleft_q - 4'h1;
                if (tleft_q == LEN_ONE) tx_st_q <= TX_IDLE;
            end
        end
    end

    // ---------------------------------------------------------------
    // Receiver
    // ---------------------------------------------------------------
    sp_rx_e rx_st_q;
    logic [8:0] rsh_q;
    logic [3:0] rleft_q;
    logic [6:0] rcnt_q;
    wire logic abe = bdc_q[B_AB_EN] & ~syn & pen;
    wire logic rx_slv = syn & ~mst;
    wire logic rx_on = pen & ~ovr_q & (syn ? rx_req : (cre & ~abe));
    wire logic rx_smp = rx_slv ? ck_act : (tick & (rcnt_q == half));
    wire logic rx_end = rx_slv ? ck_act : (tick & (rcnt_q == last));
    wire logic rx_bit = syn ? rx_s2_q : maj;
    wire logic in_data = (rx_st_q == RX_DATA);
    wire logic dsmp = rx_smp & in_data;
    wire logic [3:0] rleft_nx = dsmp ? rleft_q - 4'h1 : rleft_q;
    wire logic [8:0] rsh_nx = dsmp ? {rx_bit, rsh_q[8:1]} : rsh_q;
    wire logic [7:0] rch = nine_r ? rsh_nx[7:0] : rsh_nx[8:1];
    wire logic rch9 = nine_r & rsh_nx[8];
    wire logic [3:0] rlen = nine_r ? LEN_D9 : LEN_D8;
    wire logic bits_out = in_data & rx_end & (rleft_nx == 4'h0);
    wire logic rx_done = syn ? bits_out : (rx_st_q == RX_STOP) & rx_smp;
    wire logic rx_keep = ~(~syn & nine_r & rxc_q[B_ADDR_DET] & ~rch9);
    wire logic rx_acc = rx_done & rx_keep;
    wire logic rx_load = rx_acc & (~buff_q | rd_buf);
    wire logic ovr_set = rx_acc & buff_q & ~rd_buf;
    wire logic rx_idle = (rx_st_q == RX_IDLE);

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_st_q <= RX_IDLE;
            rsh_q <= 9'h000;
            rleft_q <= 4'h0;
            rcnt_q <= 7'h00;
        end else if (!rx_on) begin
            rx_st_q <= RX_IDLE;
            rcnt_q <= 7'h00;
        end else begin
            if (rx_idle) rcnt_q <= 7'h00;
            else if (tick) rcnt_q <= (rcnt_q == last) ? 7'h00 : rcnt_q + 7'h01;
            rsh_q <= rsh_nx;
            rleft_q <= rleft_nx;
            case (rx_st_q)
                RX_IDLE: begin
                    rleft_q <= rlen;
                    if (syn) rx_st_q <= RX_DATA;
                    else if (rx_fall) rx_st_q <= RX_START;
                end
                RX_START: begin
                    if (rx_smp & rx_bit) rx_st_q <= RX_IDLE;
                    else if (rx_end) rx_st_q <= RX_DATA;
                end
                RX_DATA: begin
                    if (bits_out) rx_st_q <= syn ? RX_IDLE : RX_STOP;
                end
                RX_STOP: begin
                    if (rx_smp) rx_st_q <= RX_IDLE;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Auto-baud measurement over four bit pairs
    // ---------------------------------------------------------------
    sp_ab_e ab_st_q;
    logic [9:0] pre_q;
    logic [15:0] abc_q;
    logic [2:0] edg_q;
    wire logic [9:0] pre_last = {bt, 3'h0} - 10'h001;
    wire logic pre_wrap = (ab_st_q == AB_MEAS) & (pre_q == pre_last);
    wire logic ab_ovf = pre_wrap & (abc_q == 16'hffff);
    wire logic ab_done = (ab_st_q == AB_MEAS) & rx_rise & (edg_q == AB_RISES - 3'h1);
    wire logic [15:0] ab_res = abc_q - 16'h0001;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ab_st_q <= AB_IDLE;
            pre_q <= 10'h000;
            abc_q <= 16'h0000;
            edg_q <= 3'h0;
        end else if (!abe || ab_ovf || ab_done) begin
            ab_st_q <= abe ? AB_IDLE : AB_FALL;
        end else begin
            case (ab_st_q)
                AB_IDLE: ab_st_q <= AB_IDLE;
                AB_FALL: if (rx_fall) ab_st_q <= AB_RISE;
                AB_RISE: begin
                    pre_q <= 10'h000;
                    abc_q <= 16'h0000;
                    edg_q <= 3'h0;
                    if (rx_rise) ab_st_q <= AB_MEAS;
                end
                AB_MEAS: begin
                    pre_q <= pre_wrap ? 10'h000 : pre_q + 10'h001;
                    if (pre_wrap) abc_q <= abc_q + 16'h0001;
                    if (rx_rise) edg_q <= edg_q + 3'h1;
                end
                default: ab_st_q <= AB_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Control and status next values
    // ---------------------------------------------------------------
    wire logic sre_clr = rx_done & syn & mst & ~cre;
    wire logic wake_en = pen & bdc_q[B_WAKE];
    wire logic wake_evt = wake_en & ~warm_q & rx_fall;
    wire logic wake_clr = warm_q & rx_rise;
    wire logic brk_clr = tx_done & tbrk_q;
    wire logic ab_start = wr_bdc & reg_wdata_in[B_AB_EN];

    assign txc_d = wr_txc ? reg_wdata_in : txc_q & ~(brk_clr ? M_BREAK : REG_RST);
    assign rxc_d = wr_rxc ? reg_wdata_in & RXC_WR_MASK :
                   rxc_q & ~(sre_clr ? M_SRE : REG_RST);
    assign bdc_d = wr_bdc ? reg_wdata_in & BAUD_WR_MASK :
                   bdc_q & ~(wake_clr ? M_WAKE : REG_RST) &
                   ~((ab_done | ab_ovf) ? M_AB_EN : REG_RST);
    assign dlo_d = wr_dlo ? reg_wdata_in : ab_done ? ab_res[7:0] : dlo_q;
    assign dhi_d = wr_dhi ? reg_wdata_in : ab_done ? ab_res[15:8] : dhi_q;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {txc_q, rxc_q, bdc_q} <= {REG_RST, REG_RST, REG_RST};
            {dlo_q, dhi_q, txd_q, buf_q} <= {REG_RST, REG_RST, REG_RST, REG_RST};
            {txf_q, buff_q, framing_error_q, ovr_q} <= 4'h0;
            {n9r_q, abovf_q, wfl_q, warm_q} <= 4'h0;
            // Pins released and idle high while in reset
            {pins_q, rdata_q} <= {4'hf, REG_RST};
        end else begin
            {txc_q, rxc_q, bdc_q, dlo_q, dhi_q} <= {txc_d, rxc_d, bdc_d, dlo_d, dhi_d};
            if (wr_txd) txd_q <= reg_wdata_in;
            txf_q <= pen & (wr_txd | (txf_q & ~tx_load));
            buff_q <= pen & (rx_load | (buff_q & ~rd_buf));
            ovr_q <= pen & (ovr_set | (ovr_q & cre));
            if (rx_load) begin
                buf_q <= rch;
                n9r_q <= rch9;
                framing_error_q <= ~syn & ~rx_bit;
            end
            abovf_q <= ab_ovf | (abovf_q & ~ab_start);
            wfl_q <= pen & (wake_evt | (wfl_q & ~rd_buf));
            warm_q <= wake_en & (wake_evt | (warm_q & ~rx_rise));
            pins_q <= pins_d;
            rdata_q <= reg_rd_in ? rd_val : REG_RST;
        end
    end

    // ---------------------------------------------------------------
    // Pins and read data
    // ---------------------------------------------------------------
    wire logic tx_hi = ~tx_idle & (tcnt_q >= half);
    wire logic rx_hi = in_data & (rcnt_q >= half);
    wire logic mclk = (tx_hi | rx_hi) ^ ~pol;
    assign pins_d.tck_o = syn ? mclk : (tx_line ^ pol);
    assign pins_d.tck_oe_n = ~(pen & (~syn | mst));
    assign pins_d.rdt_o = tx_line;
    assign pins_d.rdt_oe_n = ~(pen & syn & tx_go);

    wire logic [7:0] rd_txc = (txc_q & ~M_SH_EMPTY) |
                              (tx_idle ? M_SH_EMPTY : REG_RST);
    wire logic [7:0] rd_rxc = (rxc_q & RXC_WR_MASK) | {5'h00, framing_error_q, ovr_q, n9r_q};
    wire logic [7:0] rd_bdc = (bdc_q & BAUD_WR_MASK) | {abovf_q, rx_idle, 6'h00};
    wire logic [7:0] rd_sts = {6'h00, ~txf_q, receive_flag_out};
    assign rd_val =
        (reg_addr_in == ADR_TX_CTL) ? rd_txc :
        (reg_addr_in == ADR_RX_CTL) ? rd_rxc :
        (reg_addr_in == ADR_BAUD) ? rd_bdc :
        (reg_addr_in == ADR_DIV_LO) ? dlo_q :
        (reg_addr_in == ADR_DIV_HI) ? dhi_q :
        (reg_addr_in == ADR_RX_BUF) ? buf_q :
        (reg_addr_in == ADR_STATUS) ? rd_sts : REG_RST;

    assign reg_rdata_out = rdata_q;
    assign pins_out = pins_q;
    assign receive_flag_out = buff_q | wfl_q;
    assign wake_out = wake_evt;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    pen_hold_a: assert property (!pen |=> tx_idle && rx_idle && pins_out.tck_oe_n)
        else $error("engines active while port disabled");
    clk_src_a: assert property (pen && syn && !mst |=> pins_out.tck_oe_n)
        else $error("slave drives clock pin");
    nine_len_a: assert property (tx_load && !brk_now && !syn && txc_q[B_NINE_SEND] |=> tleft_q == LEN_A9 && tsh_q[P_NINTH] == $past(txc_q[B_NINTH_SEND]))
        else $error("nine-bit frame wrong");
    tx_yield_a: assert property (rx_req |-> !tx_load ##1 tx_idle)
        else $error("transmit during sync receive");
    brk_len_a: assert property (tx_load && brk_now |=> tleft_q == LEN_BREAK && !tsh_q[0])
        else $error("break frame wrong");
    brk_clr_a: assert property (brk_clr && !wr_txc |=> !txc_q[B_BREAK])
        else $error("break bit not cleared");
    empty_rd_a: assert property (reg_rd_in && reg_addr_in == ADR_TX_CTL |=> reg_rdata_out[B_SH_EMPTY] == $past(tx_idle))
        else $error("shifter empty wrong");
    sre_clr_a: assert property (sre_clr && !wr_rxc |=> !rxc_q[B_SRE])
        else $error("single receive not cleared");
    addr_skip_a: assert property (rx_done && !rx_keep |=> !$rose(buff_q))
        else $error("address filter failed");
    ovr_set_a: assert property (ovr_set |=> ovr_q ##1 (ovr_q || !$past(cre)))
        else $error("overrun not set");
    baud_rst_a: assert property (pen && (wr_dlo || wr_dhi) |=> bg_q == 16'h0000 ##1 (bg_q == div || !pen))
        else $error("baud timer not restarted");
    pol_out_a: assert property (pen && !syn |=> pins_out.tck_o == $past(tx_line ^ pol))
        else $error("async polarity wrong");
    wake_clr_a: assert property (wake_clr && !wr_bdc |=> !bdc_q[B_WAKE])
        else $error("wake enable not cleared");
    rsvd_rd_a: assert property (reg_rd_in && reg_addr_in == ADR_BAUD |=> (reg_rdata_out & BAUD_RSVD) == REG_RST)
        else $error("reserved bits nonzero");

    brk_c: cover property (brk_clr);
    ovr_c: cover property (ovr_set);
    ab_c: cover property (ab_done);
    sync_rx_c: cover property (rx_load && syn);
endmodule : sp_serial_port
`default_nettype wire

// >>> tb/sp_line_partner.sv
// Serial line partner: sends and catches async frames
`timescale 1ns/1ps
`default_nettype none
module sp_line_partner #(parameter int BIT = 4) (
    // Line
    input wire logic clk_in,
    input wire logic line_in,
    output logic line_out
);
    task automatic send(input logic [7:0] b, input logic stp);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (BIT) @(posedge clk_in);
        end
        line_out <= 1'b1;
    endtask : send
    task automatic catch(output logic [7:0] b);
        int n;
        n = 0;
        while (line_in !== 1'b0 && n < 400) begin
            @(posedge clk_in);
            n++;
        end
        repeat (BIT / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_in);
            b[i] = line_in;
        end
    endtask : catch
    initial line_out = 1'b1;
endmodule : sp_line_partner
`default_nettype wire

// >>> tb/enhanced_serial_port_control_test.sv
// Bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module enhanced_serial_port_control_test;
    import sp_pkg::*;
    logic core_clk_in, resetn_in, wr, rd, p_rx, tck, rdt, flag, wake;
    logic [7:0] addr, wdata, rdata, got;
    sp_pins_s pins;
    int n_errors, samples_checked;
    int n_wake = 0;
    logic [15:0] rows [5] = '{16'h9802, 16'h9b40, 16'h1800, 16'h9900, 16'h0000};
    // Pull-up on the clock pin; data pin is wired-AND with the partner
    assign tck = pins.tck_oe_n ? 1'b1 : pins.tck_o;
    assign rdt = pins.rdt_oe_n ? p_rx : pins.rdt_o & p_rx;
    sp_serial_port sp_serial_port_inst (.core_clk_in(core_clk_in),
        .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .transmit_clock_pin_in(tck), .receive_data_pin_in(rdt),
        .pins_out(pins), .receive_flag_out(flag), .wake_out(wake));
    sp_line_partner sp_line_partner_inst (.clk_in(core_clk_in),
        .line_in(tck), .line_out(p_rx));
    // Counts wake pulses, each one cycle long
    always @(posedge core_clk_in) if (wake === 1'b1) n_wake <= n_wake + 1;
    task automatic chk(input string nm, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, e);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask : rd_chk
    task automatic give_verdict;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    initial begin
        #400us;
        n_errors++;
        give_verdict();
    end
    initial begin
        {resetn_in, wr, rd, addr, wdata, n_errors, samples_checked} = '0;
        repeat (4) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        foreach (rows[i]) rd_chk(rows[i][15:8], rows[i][7:0]);
        $display("done reset values");
        wr_reg(ADR_BAUD, 8'hfc);
        rd_chk(ADR_BAUD, 8'h58);
        wr_reg(ADR_BAUD, 8'h08);
        wr_reg(ADR_TX_CTL, 8'h24);
        wr_reg(ADR_DIV_LO, 8'h00);
        wr_reg(ADR_RX_CTL, 8'h90);
        fork
            sp_line_partner_inst.catch(got);
            begin
                wr_reg(ADR_TX_DATA, 8'ha5);
                repeat (4) @(posedge core_clk_in);
                rd_chk(ADR_TX_CTL, 8'h24);
            end
        join
        chk("tx byte", got, 8'ha5);
        wr_reg(ADR_TX_CTL, 8'h65);
        fork
            sp_line_partner_inst.catch(got);
            wr_reg(ADR_TX_DATA, 8'h5a);
        join
        chk("tx nine", got, 8'h5a);
        repeat (12) @(posedge core_clk_in);
        wr_reg(ADR_TX_CTL, 8'h2c);
        fork
            sp_line_partner_inst.catch(got);
            wr_reg(ADR_TX_DATA, 8'hff);
        join
        chk("break", got, 8'h00);
        repeat (24) @(posedge core_clk_in);
        rd_chk(ADR_TX_CTL, 8'h26);
        $display("done transmit");
        sp_line_partner_inst.send(8'h3c, 1'b1);
        repeat (8) @(posedge core_clk_in);
        rd_chk(ADR_RX_CTL, 8'h90);
        chk("rx flag", {7'h00, flag}, 8'h01);
        rd_chk(ADR_RX_BUF, 8'h3c);
        chk("rx flag", {7'h00, flag}, 8'h00);
        sp_line_partner_inst.send(8'hc3, 1'b0);
        repeat (8) @(posedge core_clk_in);
        rd_chk(ADR_RX_CTL, 8'h94);
        rd_chk(ADR_RX_BUF, 8'hc3);
        $display("done receive");
        wr_reg(ADR_RX_CTL, 8'h00);
        rd_chk(ADR_BAUD, 8'h48);
        wr_reg(ADR_BAUD, 8'h0a);
        wr_reg(ADR_RX_CTL, 8'h80);
        sp_line_partner_inst.send(8'hff, 1'b1);
        rd_chk(ADR_BAUD, 8'h48);
        chk("wake flag", {7'h00, flag}, 8'h01);
        chk("wake pulses", n_wake[7:0], 8'h01);
        $display("done wake");
        give_verdict();
    end
endmodule : enhanced_serial_port_control_test
`default_nettype wire
